// ==== drfa_refresh_top.sv ====
`timescale 1ns/1ps
`include "drfa_params.svh"


module drfa_refresh_top
   import drfa_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // cycle requests from bus control
   input  wire logic       mc_req,
   input  wire logic       rc_req,
   // bus address and page selection
   input  wire logic [5:0] bus_row_addr,
   input  wire logic [5:0] bus_col_addr,
   input  wire logic [3:0] bus_page,
   // cycle state
   output logic            machine_cycle_ff,
   output logic            refresh_cycle_ff,
   output logic            column_addr_en_ff,
   output logic            refresh_advance_strobe,
   // dram side
   output logic [5:0]      ram_addr,
   output logic [3:0]      page_line,
   output logic [3:0]      ras_n,
   output logic            drv_en_lo,
   output logic            drv_en_hi
);

   // ==========================================================
   // timing constants
   localparam logic [3:0] TICK_LAST  = 4'(`DRFA_CYCLE_CNT - 1);
   localparam logic [3:0] CAE_TICK   = 4'(`DRFA_CAE_CNT);
   localparam logic [3:0] PAGE_TICKS = 4'(`DRFA_PAGE_CNT);
   localparam logic [7:0] SPONT_LAST = 8'(`DRFA_SPONT_CNT - 1);

   // ==========================================================
   // sequencer state
   drfa_state_type state_ff;
   drfa_state_type nxt_state;
   logic [3:0]     tick_ff;
   logic [3:0]     nxt_tick;
   logic [7:0]     spont_ff;
   logic [7:0]     nxt_spont;
   logic           rc_pend_ff;
   logic           nxt_rc_pend;
   logic           cae_ff;
   logic           nxt_cae;
   logic           strobe_ff;
   logic           nxt_strobe;
   logic           cyc_end;
   logic           spont_due;
   logic           in_refr;

   // counter stages
   logic [3:0]     lo_q;
   logic [3:0]     hi_q;
   logic           lo_carry;
   logic [7:0]     cnt;
   logic [1:0]     page_bits;
   logic [5:0]     refresh_row;
   logic [3:0]     page_mux;

   // dram side registers
   logic           mc_ff;
   logic           nxt_mc;
   logic           rc_ff;
   logic           nxt_rc;
   logic [5:0]     addr_ff;
   logic [5:0]     nxt_addr;
   logic [3:0]     page_ff;
   logic [3:0]     nxt_page;
   logic [3:0]     ras_n_ff;
   logic [3:0]     nxt_ras_n;
   logic           drv_lo_ff;
   logic           nxt_drv_lo;
   logic           drv_hi_ff;
   logic           nxt_drv_hi;
   logic           ras_on;

   // ==========================================================
   // cycle sequencer
   assign in_refr   = (state_ff == st_refr);
   assign cyc_end   = (state_ff != st_idle) && (tick_ff == TICK_LAST);
   assign spont_due = (spont_ff >= SPONT_LAST);

   // machine cycles win a tie; a refresh never preempts one
   always_comb begin
      nxt_state   = state_ff;
      nxt_tick    = tick_ff + 4'h1;
      nxt_rc_pend = rc_pend_ff;
      case (state_ff)
         st_idle: begin
            nxt_tick = 4'h0;
            if (mc_req) begin
               nxt_state = st_mach;
            end else if (rc_pend_ff || rc_req || spont_due) begin
               nxt_state = st_refr;
            end
         end
         st_mach: begin
            if (rc_req) begin
               nxt_rc_pend = 1'b1;
            end
            if (cyc_end) begin
               nxt_tick  = 4'h0;
               nxt_state = (rc_pend_ff || rc_req) ? st_refr : st_idle;
            end
         end
         st_refr: begin
            // mc_req is ignored here; bus control must retry
            if (cyc_end) begin
               nxt_tick  = 4'h0;
               nxt_state = st_idle;
            end
         end
         default: begin
            nxt_state = st_idle;
            nxt_tick  = 4'h0;
         end
      endcase
      if (nxt_state == st_refr && state_ff != st_refr) begin
         nxt_rc_pend = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff   <= st_idle;
         tick_ff    <= 4'h0;
         rc_pend_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         tick_ff    <= nxt_tick;
         rc_pend_ff <= nxt_rc_pend;
      end
   end

   // ==========================================================
   // spontaneous refresh timer: charges while no refresh runs
   // a machine cycle only blocks the trigger, not the charging
   always_comb begin
      nxt_spont = spont_ff;
      if (in_refr) begin
         nxt_spont = 8'h00;
      end else if (!spont_due) begin
         nxt_spont = spont_ff + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         spont_ff <= 8'h00;
      end else begin
         spont_ff <= nxt_spont;
      end
   end

   // ==========================================================
   // column enable and advance strobe
   // J comes from the active cycle; idle never sets it
   always_comb begin
      nxt_cae    = cae_ff;
      nxt_strobe = 1'b0;
      if (cyc_end) begin
         nxt_cae = 1'b0;
      end else if (tick_ff == CAE_TICK) begin
         nxt_cae = (state_ff != st_idle);
      end
      // strobe lands one tick before the end so cae still holds
      if (in_refr && tick_ff == TICK_LAST - 4'h1) begin
         nxt_strobe = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cae_ff    <= 1'b0;
         strobe_ff <= 1'b0;
      end else begin
         cae_ff    <= nxt_cae;
         strobe_ff <= nxt_strobe;
      end
   end

   // ==========================================================
   // refresh counter, low stage gated by column enable
   drfa_count4 u_lo (
      .clk    (clk),
      .nrst   (nrst),
      .cnt_en (cae_ff),
      .adv    (strobe_ff),
      .q      (lo_q),
      .carry  (lo_carry)
   );

   drfa_count4 u_hi (
      .clk    (clk),
      .nrst   (nrst),
      .cnt_en (lo_carry),
      .adv    (strobe_ff),
      .q      (hi_q),
      .carry  ()
   );

   // low two bits page, upper six row, wraps at FF
   assign cnt         = {hi_q, lo_q};
   assign page_bits   = cnt[`DRFA_PAGE_MSB:`DRFA_PAGE_LSB];
   assign refresh_row = cnt[`DRFA_ROW_MSB:`DRFA_ROW_LSB];

   // ==========================================================
   // page selection
   drfa_page_sel u_page (
      .refresh_on (in_refr),
      .page_bits  (page_bits),
      .bus_page   (bus_page),
      .page_sel   (page_mux)
   );

   // strobe window is shared by refresh and machine cycles
   assign ras_on = (state_ff != st_idle) && (tick_ff < PAGE_TICKS);

   // ==========================================================
   // dram side outputs
   always_comb begin
      nxt_mc     = (nxt_state == st_mach);
      nxt_rc     = (nxt_state == st_refr);
      nxt_addr   = cae_ff ? bus_col_addr : bus_row_addr;
      nxt_page   = 4'h0;
      nxt_drv_lo = 1'b0;
      nxt_drv_hi = 1'b0;
      if (in_refr && !cae_ff) begin
         nxt_addr = refresh_row;
      end
      if (ras_on) begin
         nxt_page = page_mux;
      end
      // each driver group serves one pair of pages
      if (in_refr) begin
         nxt_drv_lo = !page_bits[1];
         nxt_drv_hi = page_bits[1];
      end else if (state_ff == st_mach) begin
         nxt_drv_lo = |bus_page[1:0];
         nxt_drv_hi = |bus_page[3:2];
      end
      nxt_ras_n = ~(nxt_page & {4{ras_on}});
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mc_ff     <= 1'b0;
         rc_ff     <= 1'b0;
         addr_ff   <= 6'h00;
         page_ff   <= 4'h0;
         ras_n_ff  <= 4'hF;
         drv_lo_ff <= 1'b0;
         drv_hi_ff <= 1'b0;
      end else begin
         mc_ff     <= nxt_mc;
         rc_ff     <= nxt_rc;
         addr_ff   <= nxt_addr;
         page_ff   <= nxt_page;
         ras_n_ff  <= nxt_ras_n;
         drv_lo_ff <= nxt_drv_lo;
         drv_hi_ff <= nxt_drv_hi;
      end
   end

   assign machine_cycle_ff       = mc_ff;
   assign refresh_cycle_ff       = rc_ff;
   assign column_addr_en_ff      = cae_ff;
   assign refresh_advance_strobe = strobe_ff;
   assign ram_addr               = addr_ff;
   assign page_line              = page_ff;
   assign ras_n                  = ras_n_ff;
   assign drv_en_lo              = drv_lo_ff;
   assign drv_en_hi              = drv_hi_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_cnt_step_once: assert property (
      (strobe_ff && cae_ff) |=> cnt == 8'($past(cnt) + 8'h01))
      else $error("refresh counter did not step by one");

   a_cnt_holds: assert property (
      !(strobe_ff && cae_ff) |=> cnt == $past(cnt))
      else $error("refresh counter moved outside advance");

   a_cnt_needs_cae: assert property (
      (cnt != $past(cnt)) |-> $past(cae_ff))
      else $error("counter moved without column enable");

   a_carry_gated: assert property (
      lo_carry |-> (cae_ff && lo_q == 4'hF))
      else $error("carry active while low stage disabled");

   a_cae_needs_cycle: assert property (
      $rose(cae_ff) |-> $past(state_ff != st_idle))
      else $error("column enable set with no active cycle");

   a_row_mux: assert property (
      (in_refr && !cae_ff) |=> ram_addr == $past(refresh_row))
      else $error("refresh row missing on ram address");

   a_page_onehot: assert property (
      (in_refr && ras_on) |=> page_line == (4'h1 << $past(page_bits)))
      else $error("refresh page line not one-hot of count");

   a_row_stable: assert property (
      (strobe_ff && cae_ff && page_bits != 2'h3)
         |=> refresh_row == $past(refresh_row))
      else $error("row changed before all pages refreshed");

   a_ras_gated: assert property (
      ((~ras_n) & ~page_line) == 4'h0)
      else $error("row strobe on a page that is not selected");

   a_drv_split: assert property (
      (in_refr) |=> (drv_en_lo != drv_en_hi))
      else $error("refresh drives both or no driver groups");

   a_spont_start: assert property (
      (state_ff == st_idle && spont_due && !mc_req)
         |=> (state_ff == st_refr) ##1 refresh_cycle_ff)
      else $error("spontaneous refresh did not start");

   a_rc_ends: assert property (
      (in_refr && cyc_end) |=> state_ff == st_idle ##1 !refresh_cycle_ff)
      else $error("refresh cycle did not end with cycle end");

   c_spont: cover property (
      (state_ff == st_idle && spont_due) ##1 in_refr);
   c_mc_then_rc: cover property (
      (state_ff == st_mach && cyc_end && rc_pend_ff) ##1 in_refr);
   c_row_step: cover property (
      (strobe_ff && cae_ff && page_bits == 2'h3) ##1 page_bits == 2'h0);

endmodule // drfa_refresh_top

// ==== drfa_params.svh ====
`ifndef DRFA_PARAMS_SVH
`define DRFA_PARAMS_SVH

// ==========================================================
// clock and cycle timing, times in ns as printed
`define DRFA_CLK_NS      50
`define DRFA_CYCLE_NS    520
`define DRFA_CAE_NS      150
`define DRFA_PAGE_NS     400
`define DRFA_SPONT_NS    4000

// derived cycle counts: least times round up, longest round down
`define DRFA_CYCLE_CNT   ((`DRFA_CYCLE_NS + `DRFA_CLK_NS - 1) / `DRFA_CLK_NS)
`define DRFA_CAE_CNT     ((`DRFA_CAE_NS + `DRFA_CLK_NS - 1) / `DRFA_CLK_NS)
`define DRFA_PAGE_CNT    (`DRFA_PAGE_NS / `DRFA_CLK_NS)
`define DRFA_SPONT_CNT   ((`DRFA_SPONT_NS + `DRFA_CLK_NS - 1) / `DRFA_CLK_NS)

// ==========================================================
// field positions in the refresh counter
`define DRFA_PAGE_LSB    0
`define DRFA_PAGE_MSB    1
`define DRFA_ROW_LSB     2
`define DRFA_ROW_MSB     7

// reset values
`define DRFA_CNT_RST     8'h00
`define DRFA_STAGE_RST   4'h0

`endif

// ==== drfa_pkg.sv ====
package drfa_pkg;

   // ==========================================================
   // cycle sequencer states
   typedef enum logic [1:0] {
      st_idle,
      st_mach,
      st_refr
   } drfa_state_type;

endpackage

// ==== drfa_count4.sv ====
`timescale 1ns/1ps
`include "drfa_params.svh"

module drfa_count4 (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // count control
   input  wire logic       cnt_en,
   input  wire logic       adv,
   // stage outputs
   output logic [3:0]      q,
   output logic            carry
);

   logic [3:0] q_ff;
   logic [3:0] nxt_q;

   // ==========================================================
   // next count: steps only when enabled and strobed
   always_comb begin
      nxt_q = q_ff;
      if (cnt_en && adv) begin
         nxt_q = q_ff + 4'h1;   // wraps F to 0
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q_ff <= `DRFA_STAGE_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // carry only while this stage itself is enabled
   assign q     = q_ff;
   assign carry = cnt_en && (q_ff == 4'hF);

endmodule // drfa_count4

// ==== drfa_page_sel.sv ====
`timescale 1ns/1ps

module drfa_page_sel (
   // select source
   input  wire logic       refresh_on,
   input  wire logic [1:0] page_bits,
   input  wire logic [3:0] bus_page,
   // page lines
   output logic [3:0]      page_sel
);

   // ==========================================================
   // two bits to one of four lines
   function automatic logic [3:0] decode2(input logic [1:0] b);
      logic [3:0] r;
      r = 4'h0;
      r[b] = 1'b1;
      return r;
   endfunction

   // refresh takes the decoder, otherwise the bus page selects
   always_comb begin
      page_sel = refresh_on ? decode2(page_bits) : bus_page;
   end

endmodule // drfa_page_sel

// ==== drfa_dram_model.sv ====
`timescale 1ns/1ps

// ==========================================================
// four-page dram array seen from its row strobes
module drfa_dram_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // strobes and address from the block
   input  wire logic [3:0] ras_n,
   input  wire logic [3:0] page_line,
   input  wire logic [5:0] ram_addr,
   // observations for the bench
   output logic            all_rows,
   output logic [7:0]      faults
);
   logic [3:0]  ras_d_ff;
   logic [63:0] done_ff [4];

   // a row counts as refreshed on the falling strobe, as in a real array
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ras_d_ff <= 4'hF;
         faults <= 8'h00;
         for (int p = 0; p < 4; p++) done_ff[p] <= 64'h0;
      end else begin
         ras_d_ff <= ras_n;
         for (int p = 0; p < 4; p++) begin
            if (ras_d_ff[p] && !ras_n[p]) done_ff[p][ram_addr] <= 1'b1;
         end
         // a strobe on an unselected page would corrupt that page
         if ((~ras_n & ~page_line) != 4'h0) faults <= faults + 8'h01;
      end
   end

   // every row of every page seen at least once
   always_comb all_rows = &{done_ff[0], done_ff[1], done_ff[2], done_ff[3]};
endmodule // drfa_dram_model

// ==== drfa_refresh_top_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end

module drfa_refresh_top_tb;
   logic       clk, nrst, mc_req, rc_req;
   logic [5:0] bus_row_addr, bus_col_addr, ram_addr;
   logic [3:0] bus_page, page_line, ras_n;
   logic       machine_cycle_ff, refresh_cycle_ff, column_addr_en_ff;
   logic       refresh_advance_strobe, drv_en_lo, drv_en_hi, all_rows;
   logic [7:0] faults, cnt;
   int         bad_count, checks_done, n;

   drfa_refresh_top dut (.clk, .nrst, .mc_req, .rc_req, .bus_row_addr,
      .bus_col_addr, .bus_page, .machine_cycle_ff, .refresh_cycle_ff,
      .column_addr_en_ff, .refresh_advance_strobe, .ram_addr, .page_line,
      .ras_n, .drv_en_lo, .drv_en_hi);
   drfa_dram_model ram (.clk, .nrst, .ras_n, .page_line, .ram_addr,
      .all_rows, .faults);

   // ==========================================================
   // clock and shared tasks
   always #25 clk = ~clk;

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // bounded wait on a cycle flag; k returns the cycles spent
   task automatic wait_for(input int w, input logic lvl, output int k);
      logic s;
      for (k = 0; k < 200; k++) begin
         s = w ? machine_cycle_ff : refresh_cycle_ff;
         if (s === lvl) return;
         @(posedge clk);
         #1;
      end
      bad_count++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, s, lvl);
      wrap_up;
   endtask

   // follows one refresh cycle and checks it against the model count
   task automatic watch_refresh;
      int hi, pg, st, k;
      logic [3:0] oh;
      hi = 0;
      pg = 0;
      st = 0;
      oh = 4'h1 << cnt[1:0];
      wait_for(0, 1'b1, k);
      // strobe and drivers follow the cycle flag by one clock
      while (refresh_cycle_ff === 1'b1 && hi < 40) begin
         hi++;
         if (hi == 2) begin
            `CHK(ras_n, ~oh)
            `CHK({drv_en_hi, drv_en_lo}, cnt[1] ? 2'h2 : 2'h1)
         end
         if (page_line !== 4'h0) begin
            pg++;
            `CHK(page_line, oh)
         end
         if (hi > 1 && column_addr_en_ff === 1'b0) begin
            `CHK(ram_addr, cnt[7:2])
         end
         if (refresh_advance_strobe === 1'b1) begin
            st++;
            `CHK(column_addr_en_ff, 1'b1)
         end
         @(posedge clk);
         #1;
      end
      `CHK(hi, 11)
      `CHK(pg, 8)
      `CHK(st, 1)
      cnt = cnt + 8'h01;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      `CHK(ras_n, 4'hF)
      `CHK({machine_cycle_ff, refresh_cycle_ff, page_line}, 6'h00)
      $display("test reset done");
   endtask

   // full wrap: rows stay put over four pages, then step by one
   task automatic t_sequence;
      for (int r = 0; r < 260; r++) begin
         @(posedge clk) rc_req <= 1'b1;
         @(posedge clk) rc_req <= 1'b0;
         #1;
         watch_refresh;
      end
      `CHK(all_rows, 1'b1)
      $display("test sequence done");
   endtask

   // idle bus: refresh must run by itself at 3.8 to 6 usec
   task automatic t_spont;
      for (int r = 0; r < 4; r++) begin
         wait_for(0, 1'b1, n);
         `CHK((n + 11 >= 76) && (n + 11 <= 120), 1'b1)
         watch_refresh;
         wait_for(0, 1'b0, n);
      end
      $display("test spontaneous done");
   endtask

   // machine cycle with a refresh request parked behind it
   task automatic t_machine;
      int st;
      logic saw;
      st = 0;
      saw = 1'b0;
      @(posedge clk) mc_req <= 1'b1;
      @(posedge clk) mc_req <= 1'b0;
      #1;
      wait_for(1, 1'b1, n);
      `CHK(ram_addr, bus_row_addr)
      @(posedge clk);
      #1;
      `CHK(page_line, bus_page)
      @(posedge clk) rc_req <= 1'b1;
      @(posedge clk) rc_req <= 1'b0;
      #1;
      while (machine_cycle_ff === 1'b1 && st < 40) begin
         if (refresh_advance_strobe === 1'b1) st = st + 100;
         if (column_addr_en_ff === 1'b1) saw = 1'b1;
         @(posedge clk);
         #1;
      end
      `CHK(st, 0)
      `CHK(saw, 1'b1)
      watch_refresh;
      $display("test machine done");
   endtask

   // machine request during a refresh leaves no trace
   task automatic t_refuse;
      @(posedge clk) rc_req <= 1'b1;
      @(posedge clk) begin
         rc_req <= 1'b0;
         mc_req <= 1'b1;
      end
      #1;
      // drop the machine request while the refresh is being watched
      fork
         watch_refresh;
         begin
            @(posedge clk) mc_req <= 1'b0;
         end
      join
      for (int k = 0; k < 15; k++) begin
         `CHK(machine_cycle_ff, 1'b0)
         @(posedge clk);
         #1;
      end
      `CHK(faults, 8'h00)
      $display("test refuse done");
   endtask

   // ==========================================================
   // main sequence
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      mc_req = 1'b0;
      rc_req = 1'b0;
      bus_row_addr = 6'h2A;
      bus_col_addr = 6'h15;
      bus_page = 4'h4;
      cnt = 8'h00;
      bad_count = 0;
      checks_done = 0;
      repeat (16) @(posedge clk);
      #1;
      t_reset;
      @(posedge clk) nrst <= 1'b1;
      t_sequence;
      t_spont;
      t_machine;
      t_refuse;
      wrap_up;
   end
endmodule // drfa_refresh_top_tb
